// *** tvm_pkg.sv ***
// constants for the temperature and supply monitor register bank
package tvm_pkg;

    // bus widths
    localparam int ADDR_W = 16;
    localparam int DATA_W = 8;

    // register addresses
    localparam logic [ADDR_W-1:0] TEMP_CTRL_ADDR   = 16'h02F0;
    localparam logic [ADDR_W-1:0] SUPPLY_CTRL_ADDR = 16'h02F1;
    localparam logic [ADDR_W-1:0] IRQ_STATUS_ADDR  = 16'h02F8;
    localparam logic [ADDR_W-1:0] IRQ_ENABLE_ADDR  = 16'h02F9;
    localparam logic [ADDR_W-1:0] IRQ_CLEAR_ADDR   = 16'h02FA;

    // temperature control field positions
    localparam int TEST_HI_BIT     = 7;
    localparam int TEST_LO_BIT     = 6;
    localparam int SRC_SELECT_BIT  = 5;
    localparam int ROUTE_EN_BIT    = 4;
    localparam int SENSE_EN_BIT    = 3;
    localparam int STATUS_BIT      = 2;
    localparam int IRQ_EN_BIT      = 1;
    localparam int CHANGE_FLAG_BIT = 0;

    // interrupt status, enable and clear layout
    localparam int IRQ_TEMP_BIT   = 0;
    localparam int IRQ_SUPPLY_BIT = 1;

    // reset values
    localparam logic [1:0]        TEST_BITS_RST = 2'h0;
    localparam logic              CTRL_BIT_RST  = 1'h0;
    localparam logic [DATA_W-1:0] RDATA_RST     = 8'h00;

endpackage

// *** tvm_sync.sv ***
// two-stage synchroniser for the comparator outputs
`timescale 1ns/1ns
module tvm_sync
(
    input  wire logic       sys_clk_in,   // system clock
    input  wire logic       rstn_in,      // synchronous reset, active low
    input  wire logic [1:0] async_in,     // asynchronous levels
    output logic      [1:0] sync_out      // levels in the clock domain
);
    import tvm_pkg::*;

    typedef struct packed
    {
        logic [1:0] stage1;
        logic [1:0] stage2;
    } tvm_sync_state_t;

    tvm_sync_state_t st;
    tvm_sync_state_t next_st;

    ////////////////////////////////////////////////////////////////////////
    // first stage feeds only the second, never any logic
    always_comb
    begin
        next_st        = st;
        next_st.stage1 = async_in;
        next_st.stage2 = st.stage1;
    end

    // register the copy
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign sync_out = st.stage2;

endmodule

// *** tvm_regs.sv ***
// temperature and supply monitor control and status registers
// Notes on behaviour
// - the two top bits of the temperature register are test bits, writable only in special mode.
// - source select 0 routes the temperature voltage, 1 the bandgap reference.
// - route enable sends the selected voltage to the converter, else the external input.
// - sense enable switches temperature sensing on when 1 and off when 0.
// - temperature status is read-only, 1 only while hot in full performance mode.
// - temperature interrupt enable makes the change flag raise an interrupt.
// - the temperature change flag sets on any change of the temperature status.
// - both change flags clear only on a write of 1, a write of 0 leaves them.
// - reduced power mode does not clear the temperature change flag.
// - supply status is read-only, 1 only while supply is low in full performance mode.
// - supply interrupt enable makes the supply change flag raise an interrupt.
// - the supply change flag sets on any change of the supply status.
// - reduced power mode does not clear the supply change flag.
//
// The strobed register port is this design's own decision.
`timescale 1ns/1ns
module tvm_regs
(
    input  wire logic                      sys_clk_in,         // 250 MHz system clock
    input  wire logic                      rstn_in,            // synchronous reset, active low
    input  wire logic [tvm_pkg::ADDR_W-1:0] addr_in,           // register address
    input  wire logic [tvm_pkg::DATA_W-1:0] wdata_in,          // write data
    input  wire logic                      wr_in,              // write strobe
    input  wire logic                      rd_in,              // read strobe
    output logic      [tvm_pkg::DATA_W-1:0] rdata_out,         // read data, cycle after strobe
    input  wire logic                      special_mode_in,    // test mode, same clock
    input  wire logic                      full_performance_mode_in, // regulator in full power
    input  wire logic                      temp_above_in,      // hot comparator, async
    input  wire logic                      supply_below_in,    // low supply comparator, async
    output logic      [1:0]                test_bits_out,      // test bits 7 and 6
    output logic                           analog_source_select_out, // 1 bandgap, 0 temp
    output logic                           analog_route_enable_out,  // internal route on
    output logic                           adc_internal_route_out,   // converter sees internal
    output logic                           temp_sense_enable_out,    // sensor power on
    output logic                           irq_out             // level interrupt request
);
    import tvm_pkg::*;

    typedef struct packed
    {
        logic [1:0]        test_bits;
        logic              analog_source_select;
        logic              analog_route_enable;
        logic              temp_sense_enable;
        logic              temp_high_status;
        logic              temp_irq_enable;
        logic              temp_change_flag;
        logic              supply_low_status;
        logic              supply_irq_enable;
        logic              supply_change_flag;
        logic [DATA_W-1:0] rdata;
    } tvm_state_t;

    tvm_state_t st;
    tvm_state_t next_st;

    logic [1:0] comp_sync;
    logic       temp_now;
    logic       supply_now;
    logic       wr_temp;
    logic       wr_supply;
    logic       wr_irq_en;
    logic       wr_irq_clr;
    logic       clr_temp;
    logic       clr_supply;

    // sticky flag update; the set wins over a clear in the same cycle
    function automatic logic flag_next(input logic cur, input logic set, input logic clr);
        flag_next = set | (cur & ~clr);
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // comparator synchronisation
    tvm_sync u_sync
    (
        .sys_clk_in (sys_clk_in),
        .rstn_in    (rstn_in),
        .async_in   ({supply_below_in, temp_above_in}),
        .sync_out   (comp_sync)
    );

    // live status: comparator qualified by mode, sensor gated by its enable
    assign temp_now   = comp_sync[0] & full_performance_mode_in & st.temp_sense_enable;
    assign supply_now = comp_sync[1] & full_performance_mode_in;

    ////////////////////////////////////////////////////////////////////////
    // address decode
    assign wr_temp    = wr_in && (addr_in == TEMP_CTRL_ADDR);
    assign wr_supply  = wr_in && (addr_in == SUPPLY_CTRL_ADDR);
    assign wr_irq_en  = wr_in && (addr_in == IRQ_ENABLE_ADDR);
    assign wr_irq_clr = wr_in && (addr_in == IRQ_CLEAR_ADDR);

    // clear only on a written 1, through either the control or clear register
    assign clr_temp   = (wr_temp && wdata_in[CHANGE_FLAG_BIT])
                      || (wr_irq_clr && wdata_in[IRQ_TEMP_BIT]);
    assign clr_supply = (wr_supply && wdata_in[CHANGE_FLAG_BIT])
                      || (wr_irq_clr && wdata_in[IRQ_SUPPLY_BIT]);

    ////////////////////////////////////////////////////////////////////////
    // next state
    always_comb
    begin
        next_st = st;

        // control fields of the temperature register
        if (wr_temp)
        begin
            if (special_mode_in)
            begin
                next_st.test_bits = wdata_in[TEST_HI_BIT:TEST_LO_BIT];
            end
            next_st.analog_source_select = wdata_in[SRC_SELECT_BIT];
            next_st.analog_route_enable  = wdata_in[ROUTE_EN_BIT];
            next_st.temp_sense_enable    = wdata_in[SENSE_EN_BIT];
            next_st.temp_irq_enable      = wdata_in[IRQ_EN_BIT];
        end

        // control field of the supply register
        if (wr_supply)
        begin
            next_st.supply_irq_enable = wdata_in[IRQ_EN_BIT];
        end

        // enable register aliases the two documented enables
        if (wr_irq_en)
        begin
            next_st.temp_irq_enable   = wdata_in[IRQ_TEMP_BIT];
            next_st.supply_irq_enable = wdata_in[IRQ_SUPPLY_BIT];
        end

        // status follows the live level; writes never touch it
        next_st.temp_high_status  = temp_now;
        next_st.supply_low_status = supply_now;

        // any change of status sets the flag; mode changes never clear it
        next_st.temp_change_flag = flag_next(st.temp_change_flag,
                                             temp_now != st.temp_high_status,
                                             clr_temp);
        next_st.supply_change_flag = flag_next(st.supply_change_flag,
                                               supply_now != st.supply_low_status,
                                               clr_supply);

        // read data stands only in the cycle after the strobe
        next_st.rdata = RDATA_RST;
        if (rd_in)
        begin
            case (addr_in)
                TEMP_CTRL_ADDR:
                begin
                    next_st.rdata = {st.test_bits, st.analog_source_select,
                                     st.analog_route_enable, st.temp_sense_enable,
                                     st.temp_high_status, st.temp_irq_enable,
                                     st.temp_change_flag};
                end
                SUPPLY_CTRL_ADDR:
                begin
                    next_st.rdata = {5'h00, st.supply_low_status,
                                     st.supply_irq_enable, st.supply_change_flag};
                end
                IRQ_STATUS_ADDR:
                begin
                    next_st.rdata = {6'h00, st.supply_change_flag, st.temp_change_flag};
                end
                IRQ_ENABLE_ADDR:
                begin
                    next_st.rdata = {6'h00, st.supply_irq_enable, st.temp_irq_enable};
                end
                default:
                begin
                    // clear register and unmapped addresses read zero
                    next_st.rdata = RDATA_RST;
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge sys_clk_in)
    begin
        if (!rstn_in)
        begin
            st.test_bits            <= TEST_BITS_RST;
            st.analog_source_select <= CTRL_BIT_RST;
            st.analog_route_enable  <= CTRL_BIT_RST;
            st.temp_sense_enable    <= CTRL_BIT_RST;
            st.temp_high_status     <= CTRL_BIT_RST;
            st.temp_irq_enable      <= CTRL_BIT_RST;
            st.temp_change_flag     <= CTRL_BIT_RST;
            st.supply_low_status    <= CTRL_BIT_RST;
            st.supply_irq_enable    <= CTRL_BIT_RST;
            st.supply_change_flag   <= CTRL_BIT_RST;
            st.rdata                <= RDATA_RST;
        end
        else
        begin
            st <= next_st;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // outputs
    assign rdata_out                = st.rdata;
    assign test_bits_out            = st.test_bits;
    assign analog_source_select_out = st.analog_source_select;
    assign analog_route_enable_out  = st.analog_route_enable;
    // external input stays on the channel unless routing is enabled
    assign adc_internal_route_out   = st.analog_route_enable;
    assign temp_sense_enable_out    = st.temp_sense_enable;
    // level request from either enabled flag
    assign irq_out = (st.temp_change_flag & st.temp_irq_enable)
                   | (st.supply_change_flag & st.supply_irq_enable);

    ////////////////////////////////////////////////////////////////////////
    // checks

    AST_TEST_BITS_GUARD: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (wr_temp && !special_mode_in) |=> $stable(test_bits_out))
        else $error("test bits changed outside special mode");

    AST_SOURCE_SELECT: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        wr_temp |=> analog_source_select_out == $past(wdata_in[SRC_SELECT_BIT]))
        else $error("source select did not take written value");

    AST_ROUTE_EXTERNAL: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        wr_temp && !wdata_in[ROUTE_EN_BIT] |=> !adc_internal_route_out)
        else $error("internal route left on after disable");

    AST_SENSE_OFF_STATUS: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !temp_sense_enable_out |=> !st.temp_high_status)
        else $error("temperature status high with sensor off");

    AST_TEMP_STATUS_MODE: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        st.temp_high_status |-> $past(full_performance_mode_in) && $past(temp_above_in, 3))
        else $error("temperature status high without cause");

    AST_TEMP_IRQ: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (st.temp_change_flag && st.temp_irq_enable) |-> irq_out)
        else $error("enabled temperature flag gave no interrupt");

    AST_TEMP_FLAG_SET: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $changed(st.temp_high_status) |-> st.temp_change_flag)
        else $error("temperature change did not set flag");

    AST_FLAG_HOLD: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (st.supply_change_flag && !clr_supply) |=> st.supply_change_flag)
        else $error("supply flag lost without a written one");

    AST_TEMP_FLAG_KEEP: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        (st.temp_change_flag && !clr_temp) ##1 $fell(full_performance_mode_in)
        |-> st.temp_change_flag)
        else $error("temperature flag cleared on power mode change");

    AST_SUPPLY_STATUS: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !full_performance_mode_in |=> !st.supply_low_status)
        else $error("supply status high outside full performance");

    AST_NO_IRQ: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        !(st.supply_change_flag && st.supply_irq_enable)
        && !(st.temp_change_flag && st.temp_irq_enable) |-> !irq_out)
        else $error("interrupt without enabled flag");

    AST_SUPPLY_FLAG_SET: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $changed(st.supply_low_status) |-> st.supply_change_flag)
        else $error("supply change did not set flag");

    AST_SUPPLY_CLEAR_ONLY: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        $fell(st.supply_change_flag) |-> $past(clr_supply))
        else $error("supply flag cleared without a written one");

    AST_SYNC_DELAY: assert property (
        @(posedge sys_clk_in) disable iff (!rstn_in)
        st.supply_low_status |-> $past(supply_below_in, 3))
        else $error("supply status ahead of synchroniser delay");

endmodule

// *** tvm_comp_model.sv ***
// behavioural model of the analog comparators that feed the monitor
`timescale 1ns/1ns
module tvm_comp_model
#(
    parameter int DELAY_NS = 1                 // settling time after a commanded change
)
(
    input  wire logic hot_cmd_in,              // die hot request from the bench
    input  wire logic low_cmd_in,              // supply low request from the bench
    output logic      temp_above_out,          // comparator level, not clock aligned
    output logic      supply_below_out         // comparator level, not clock aligned
);
    // start cool and well supplied
    initial
    begin
        temp_above_out = 1'b0;
        supply_below_out = 1'b0;
    end

    // levels move off the clock grid, so the synchroniser is really exercised
    always @(hot_cmd_in) temp_above_out <= #(DELAY_NS) hot_cmd_in;
    always @(low_cmd_in) supply_below_out <= #(DELAY_NS) low_cmd_in;
endmodule

// *** temp_voltage_monitor_regs_tb_top.sv ***
// self-checking bench for the temperature and supply monitor registers
`timescale 1ns/1ns
module temp_voltage_monitor_regs_tb_top;
    import tvm_pkg::*;
    logic              sys_clk_in;
    logic              rstn_in;
    logic [ADDR_W-1:0] addr_in;
    logic [DATA_W-1:0] wdata_in;
    logic              wr_in;
    logic              rd_in;
    logic [DATA_W-1:0] rdata_out;
    logic              special_mode_in;
    logic              full_performance_mode;
    logic              hot_cmd;
    logic              low_cmd;
    logic              temp_above;
    logic              supply_below;
    logic [1:0]        test_bits_out;
    logic              src_sel;
    logic              route_en;
    logic              adc_route;
    logic              sense_en;
    logic              irq_out;
    int                n_mismatch;
    int                n_tests;

    ////////////////////////////////////////////////////////////////////////////
    tvm_regs i_dut (.sys_clk_in(sys_clk_in), .rstn_in(rstn_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .special_mode_in(special_mode_in), .full_performance_mode_in(full_performance_mode),
        .temp_above_in(temp_above), .supply_below_in(supply_below),
        .test_bits_out(test_bits_out), .analog_source_select_out(src_sel),
        .analog_route_enable_out(route_en), .adc_internal_route_out(adc_route),
        .temp_sense_enable_out(sense_en), .irq_out(irq_out));

    tvm_comp_model i_comp (.hot_cmd_in(hot_cmd), .low_cmd_in(low_cmd),
        .temp_above_out(temp_above), .supply_below_out(supply_below));

    // 250 MHz clock
    initial
    begin
        sys_clk_in = 1'b0;
        forever #2 sys_clk_in = ~sys_clk_in;
    end

    ////////////////////////////////////////////////////////////////////////////
    // one compare, counted; mismatches reported at once
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp, input string what);
        n_tests++;
        if (seen !== exp)
        begin
            n_mismatch++;
            $display("[ERR] %0t %s: got %h want %h", $time, what, seen, exp);
        end
    endtask

    // one-cycle write strobe, special mode level rides along with it
    task automatic wr(input logic [15:0] a, input logic [7:0] d, input logic sp);
        @(posedge sys_clk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= d;
        special_mode_in <= sp;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
        special_mode_in <= 1'b0;
    endtask

    // one-cycle read strobe, data looked at only in the following cycle
    task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
        @(posedge sys_clk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1 chk(rdata_out, exp, "read data");
    endtask

    // move the comparators and mode, then give the synchroniser time
    task automatic settle(input logic h, input logic l, input logic f);
        @(posedge sys_clk_in);
        hot_cmd <= h;
        low_cmd <= l;
        full_performance_mode <= f;
        repeat (5) @(posedge sys_clk_in);
    endtask

    task automatic print_verdict();
        $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
        if (n_mismatch == 0 && n_tests > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset();
        rd_chk(TEMP_CTRL_ADDR, 8'h00);
        rd_chk(SUPPLY_CTRL_ADDR, 8'h00);
        chk({7'h00, irq_out}, 8'h00, "irq after reset");
        $display("test reset done");
    endtask

    // control bits, test bits guarded by special mode
    task automatic t_control();
        wr(TEMP_CTRL_ADDR, 8'hFA, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'h3A);
        chk({2'h0, test_bits_out, src_sel, route_en, adc_route, sense_en}, 8'h0F, "ctl");
        chk({7'h00, irq_out}, 8'h00, "no flag no irq");
        wr(TEMP_CTRL_ADDR, 8'h20, 1'b0);
        #1 chk({2'h0, test_bits_out, src_sel, route_en, adc_route, sense_en}, 8'h08, "ctl");
        wr(TEMP_CTRL_ADDR, 8'hC0, 1'b1);
        rd_chk(TEMP_CTRL_ADDR, 8'hC0);
        chk({6'h00, test_bits_out}, 8'h03, "test bits");
        wr(TEMP_CTRL_ADDR, 8'h00, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'hC0);
        wr(TEMP_CTRL_ADDR, 8'h00, 1'b1);
        rd_chk(TEMP_CTRL_ADDR, 8'h00);
        $display("test control done");
    endtask

    // temperature flag: synchroniser delay, both edges, write one to clear
    task automatic t_temp();
        wr(TEMP_CTRL_ADDR, 8'h0A, 1'b0);
        @(posedge sys_clk_in);
        hot_cmd <= 1'b1;
        repeat (2) @(posedge sys_clk_in);
        #1 chk({7'h00, irq_out}, 8'h00, "irq too early");
        @(posedge sys_clk_in);
        #1 chk({7'h00, irq_out}, 8'h01, "irq on flag");
        rd_chk(TEMP_CTRL_ADDR, 8'h0F);
        wr(TEMP_CTRL_ADDR, 8'h0A, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'h0F);
        wr(TEMP_CTRL_ADDR, 8'h0B, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'h0E);
        chk({7'h00, irq_out}, 8'h00, "irq after clear");
        settle(1'b0, 1'b0, 1'b1);
        rd_chk(TEMP_CTRL_ADDR, 8'h0B);
        // drop to reduced power while status is already low: only the flag rule holds it
        settle(1'b0, 1'b0, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'h0B);
        settle(1'b0, 1'b0, 1'b1);
        wr(TEMP_CTRL_ADDR, 8'h08, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'h09);
        chk({7'h00, irq_out}, 8'h00, "irq masked");
        wr(TEMP_CTRL_ADDR, 8'h09, 1'b0);
        $display("test temperature done");
    endtask

    // reduced power forces status low, flag survives; sensor off too
    task automatic t_temp_rpm();
        settle(1'b1, 1'b0, 1'b1);
        wr(TEMP_CTRL_ADDR, 8'h09, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'h0C);
        settle(1'b1, 1'b0, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'h09);
        repeat (20) @(posedge sys_clk_in);
        rd_chk(TEMP_CTRL_ADDR, 8'h09);
        settle(1'b1, 1'b0, 1'b1);
        wr(TEMP_CTRL_ADDR, 8'h09, 1'b0);
        wr(TEMP_CTRL_ADDR, 8'h01, 1'b0);
        repeat (4) @(posedge sys_clk_in);
        rd_chk(TEMP_CTRL_ADDR, 8'h01);
        wr(TEMP_CTRL_ADDR, 8'h01, 1'b0);
        rd_chk(TEMP_CTRL_ADDR, 8'h00);
        $display("test temperature low power done");
    endtask

    // supply flag plus the summary interrupt registers
    task automatic t_supply();
        wr(SUPPLY_CTRL_ADDR, 8'h02, 1'b0);
        settle(1'b0, 1'b1, 1'b1);
        rd_chk(SUPPLY_CTRL_ADDR, 8'h07);
        chk({7'h00, irq_out}, 8'h01, "supply irq");
        wr(SUPPLY_CTRL_ADDR, 8'h02, 1'b0);
        rd_chk(SUPPLY_CTRL_ADDR, 8'h07);
        wr(SUPPLY_CTRL_ADDR, 8'hFF, 1'b0);
        rd_chk(SUPPLY_CTRL_ADDR, 8'h06);
        settle(1'b0, 1'b0, 1'b1);
        rd_chk(SUPPLY_CTRL_ADDR, 8'h03);
        // mode drop with no status change, so no set can mask a lost flag
        settle(1'b0, 1'b0, 1'b0);
        rd_chk(SUPPLY_CTRL_ADDR, 8'h03);
        settle(1'b0, 1'b0, 1'b1);
        rd_chk(IRQ_STATUS_ADDR, 8'h02);
        wr(IRQ_ENABLE_ADDR, 8'h00, 1'b0);
        #1 chk({7'h00, irq_out}, 8'h00, "supply masked");
        rd_chk(SUPPLY_CTRL_ADDR, 8'h01);
        wr(IRQ_CLEAR_ADDR, 8'h02, 1'b0);
        rd_chk(IRQ_STATUS_ADDR, 8'h00);
        settle(1'b0, 1'b1, 1'b1);
        wr(SUPPLY_CTRL_ADDR, 8'h01, 1'b0);
        rd_chk(SUPPLY_CTRL_ADDR, 8'h04);
        settle(1'b0, 1'b1, 1'b0);
        repeat (20) @(posedge sys_clk_in);
        rd_chk(SUPPLY_CTRL_ADDR, 8'h01);
        wr(16'h02F2, 8'hFF, 1'b1);
        rd_chk(16'h02F2, 8'h00);
        rd_chk(TEMP_CTRL_ADDR, 8'h00);
        $display("test supply done");
    endtask

    ////////////////////////////////////////////////////////////////////////////
    // main sequence: reset held 12 cycles, then each scenario in turn
    initial
    begin
        n_mismatch = 0;
        n_tests = 0;
        rstn_in = 1'b0;
        addr_in = '0;
        wdata_in = '0;
        wr_in = 1'b0;
        rd_in = 1'b0;
        special_mode_in = 1'b0;
        full_performance_mode = 1'b1;
        hot_cmd = 1'b0;
        low_cmd = 1'b0;
        repeat (12) @(posedge sys_clk_in);
        rstn_in <= 1'b1;
        t_reset();
        t_control();
        t_temp();
        t_temp_rpm();
        t_supply();
        print_verdict();
    end
endmodule
